// ### shared/scd_pkg.sv
package scd_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLOCK_HZ = 10_000_000;
  localparam int unsigned DUTY_MIN_FREQ_HZ = 5_000_000;
  // Longest period that still counts as fast, rounded down
  localparam int unsigned DUTY_MAX_PERIOD_CYC_RAW = CLOCK_HZ / DUTY_MIN_FREQ_HZ;
  localparam int unsigned DUTY_MAX_PERIOD_CYC =
    (DUTY_MAX_PERIOD_CYC_RAW < 1) ? 1 : DUTY_MAX_PERIOD_CYC_RAW;
  localparam int unsigned PERIOD_W = 8;
  localparam int unsigned PRESC_STAGES = 12;
  localparam int unsigned STBY_WAIT_STATES = 8192;
  localparam int unsigned STBY_WAIT_W = 20;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] RATIO_INDEX = 32'h000E_E01B;
  localparam logic [31:0] RATIO_ADDR = RATIO_INDEX << 2;
  localparam logic [31:0] CTRL_ADDR = 32'h003B_8080;
  localparam logic [31:0] STATUS_ADDR = 32'h003B_8084;

  localparam logic [7:0] RATIO_RESET = 8'hFC;
  localparam logic [7:0] RATIO_FIXED_ONES = 8'hFC;
  localparam int unsigned RATIO_SEL_LOW_POS = 0;
  localparam int unsigned RATIO_SEL_HIGH_POS = 1;

  localparam int unsigned CTRL_PIN_EN_POS = 0;
  localparam int unsigned CTRL_STBY_REQ_POS = 1;
  localparam logic CTRL_PIN_EN_RESET = 1'b0;

  localparam int unsigned STAT_STBY_POS = 0;
  localparam int unsigned STAT_WAIT_POS = 1;
  localparam int unsigned STAT_FAST_POS = 2;
  localparam int unsigned STAT_RATIO_POS = 3;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    RUN = 2'h0,
    STBY = 2'h1,
    WAKE = 2'h3
  } scd_pwr_e;

endpackage

// ### shared/scd_osc_if.sv
`timescale 1ns/1ns
interface scd_osc_if;
  logic oscTick;
  logic oscWave;
  logic oscFast;
  modport src (output oscTick, output oscWave, output oscFast);
  modport sink (input oscTick, input oscWave, input oscFast);
endinterface

// ### core/scd_duty_stage.sv
`timescale 1ns/1ns
module scd_duty_stage (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic oscRaw,
  scd_osc_if.src osc
);

  logic s1_q, s2_q, s3_q;
  logic lvl_q;
  logic [scd_pkg::PERIOD_W-1:0] periodCnt_q;
  logic [scd_pkg::PERIOD_W-1:0] period_q;
  logic [scd_pkg::PERIOD_W-1:0] highCnt_q;
  logic fast_q;
  logic wave_q;
  logic rise;

  // ****************************************
  // Pin synchroniser and filter
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= oscRaw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  // Edge taken ahead of the agree filter: a half-rate oscillator never settles in it
  assign rise = s2_q & ~s3_q;

  // ****************************************
  // Period measurement
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // Saturated start, so the first edge after reset never reads as fast
      periodCnt_q <= '1;
      period_q <= '1;
      fast_q <= 1'b0;
    end else if (rise) begin
      periodCnt_q <= scd_pkg::PERIOD_W'(1);
      period_q <= periodCnt_q;
      fast_q <= (periodCnt_q <= scd_pkg::PERIOD_W'(scd_pkg::DUTY_MAX_PERIOD_CYC));
    end else if (periodCnt_q != '1) begin
      periodCnt_q <= periodCnt_q + 1'b1;
    end
  end

  // ****************************************
  // Regenerated half-period waveform
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      highCnt_q <= '0;
      wave_q <= 1'b0;
    end else if (rise) begin
      highCnt_q <= (period_q >> 1) | scd_pkg::PERIOD_W'(1);
      wave_q <= 1'b1;
    end else if (highCnt_q > scd_pkg::PERIOD_W'(1)) begin
      highCnt_q <= highCnt_q - 1'b1;
    end else begin
      highCnt_q <= '0;
      wave_q <= 1'b0;
    end
  end

  // Slow oscillators pass as filtered, no correction below the limit
  assign osc.oscTick = rise;
  assign osc.oscWave = fast_q ? wave_q : lvl_q;
  assign osc.oscFast = fast_q;

endmodule

// ### core/scd_clock_divider.sv
`timescale 1ns/1ns
module scd_clock_divider #(
  parameter int unsigned PRESC_STAGES = scd_pkg::PRESC_STAGES,
  parameter int unsigned STBY_WAIT_STATES = scd_pkg::STBY_WAIT_STATES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic oscRaw,
  input wire logic hwStandby,
  input wire logic wakeReq,
  output logic sysTick,
  output logic [PRESC_STAGES-1:0] prescTick,
  output logic phiPin,
  output logic phiPinOe,
  output logic standbyActive
);

  // ****************************************
  // Parameter checks
  // ****************************************
  if (PRESC_STAGES < 1 || PRESC_STAGES > 16) begin : g_bad_presc
    $error("PRESC_STAGES out of range");
  end
  if (STBY_WAIT_STATES < 1 || STBY_WAIT_STATES >= (1 << scd_pkg::STBY_WAIT_W)) begin : g_bad_wait
    $error("STBY_WAIT_STATES out of range");
  end
  if (scd_pkg::DUTY_MAX_PERIOD_CYC >= (1 << scd_pkg::PERIOD_W)) begin : g_bad_period
    $error("DUTY_MAX_PERIOD_CYC does not fit PERIOD_W");
  end

  localparam logic [scd_pkg::STBY_WAIT_W-1:0] WAIT_LAST =
    scd_pkg::STBY_WAIT_W'(STBY_WAIT_STATES - 1);

  // ****************************************
  // Declarations
  // ****************************************
  scd_osc_if osc ();

  logic h1_q, h2_q, h3_q, hwStby_q;
  logic w1_q, w2_q, w3_q, wake_q;

  logic busWr_q;
  logic [31:0] busAddr_q;
  logic addrPhase;

  logic [1:0] ratio_q, ratio_d;
  logic pinEn_q, pinEn_d;
  logic [1:0] ratioAct_q;
  logic [2:0] divCnt_q;
  logic [2:0] divLast;
  logic phiLvl_q;
  logic phiTick;
  logic [3:0] divNext;
  logic [3:0] divHalf;
  logic [PRESC_STAGES-1:0] prescCnt_q;
  logic [PRESC_STAGES-1:0] presc_q;
  logic sysTick_q;

  scd_pkg::scd_pwr_e pwr_q;
  logic [scd_pkg::STBY_WAIT_W-1:0] waitCnt_q;
  logic stbyReq;
  logic [31:0] rdata_q;
  logic modClkRun;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [2:0] ratio_last(input logic [1:0] sel);
    case (sel)
      2'h0: ratio_last = 3'h0;
      2'h1: ratio_last = 3'h1;
      2'h2: ratio_last = 3'h3;
      2'h3: ratio_last = 3'h7;
      default: ratio_last = 3'h0;
    endcase
  endfunction

  function automatic logic [7:0] ratio_view(input logic [1:0] sel);
    ratio_view = scd_pkg::RATIO_FIXED_ONES;
    ratio_view[scd_pkg::RATIO_SEL_LOW_POS] = sel[0];
    ratio_view[scd_pkg::RATIO_SEL_HIGH_POS] = sel[1];
  endfunction

  // Data-phase write that lands on one register word
  function automatic logic wr_hit(input logic busWr, input logic [31:0] busAddr,
                                  input logic [31:0] regAddr);
    wr_hit = busWr && (busAddr == regAddr);
  endfunction

  // Low counter bits that must all be one for stage k to fire
  function automatic logic [PRESC_STAGES-1:0] presc_mask(input int unsigned k);
    presc_mask = '0;
    for (int unsigned i = 0; i <= k; i++) begin
      presc_mask[i] = 1'b1;
    end
  endfunction

  // ****************************************
  // Oscillator front end
  // ****************************************
  scd_duty_stage u_duty (
    .clock(clock),
    .rst_n(rst_n),
    .oscRaw(oscRaw),
    .osc(osc)
  );

  // ****************************************
  // Standby and wake pin synchronisers
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      h1_q <= 1'b0;
      h2_q <= 1'b0;
      h3_q <= 1'b0;
      hwStby_q <= 1'b0;
    end else begin
      h1_q <= hwStandby;
      h2_q <= h1_q;
      h3_q <= h2_q;
      if (h2_q == h3_q) begin
        hwStby_q <= h3_q;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      w1_q <= 1'b0;
      w2_q <= 1'b0;
      w3_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      w1_q <= wakeReq;
      w2_q <= w1_q;
      w3_q <= w2_q;
      if (w2_q == w3_q) begin
        wake_q <= w3_q;
      end
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Zero wait states; every response is OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel & hready & (htrans == scd_pkg::HTRANS_NONSEQ | htrans == 2'h3);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busWr_q <= 1'b0;
      busAddr_q <= 32'h0000_0000;
    end else if (hready) begin
      busWr_q <= addrPhase & hwrite & (hsize == 3'h2);
      busAddr_q <= haddr;
    end
  end

  always_comb begin
    ratio_d = ratio_q;
    pinEn_d = pinEn_q;
    if (wr_hit(busWr_q, busAddr_q, scd_pkg::RATIO_ADDR)) begin
      ratio_d[0] = hwdata[scd_pkg::RATIO_SEL_LOW_POS];
      ratio_d[1] = hwdata[scd_pkg::RATIO_SEL_HIGH_POS];
    end
    if (wr_hit(busWr_q, busAddr_q, scd_pkg::CTRL_ADDR)) begin
      pinEn_d = hwdata[scd_pkg::CTRL_PIN_EN_POS];
    end
  end

  assign stbyReq = wr_hit(busWr_q, busAddr_q, scd_pkg::CTRL_ADDR) &&
    hwdata[scd_pkg::CTRL_STBY_REQ_POS];

  // Hardware standby reloads the ratio; software standby leaves it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ratio_q <= scd_pkg::RATIO_RESET[1:0];
    end else if (hwStby_q) begin
      ratio_q <= scd_pkg::RATIO_RESET[1:0];
    end else begin
      ratio_q <= ratio_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinEn_q <= scd_pkg::CTRL_PIN_EN_RESET;
    end else if (hwStby_q) begin
      pinEn_q <= scd_pkg::CTRL_PIN_EN_RESET;
    end else begin
      pinEn_q <= pinEn_d;
    end
  end

  // Read data uses next values so a write followed by a read sees it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      rdata_q <= 32'h0000_0000;
      if (haddr == scd_pkg::RATIO_ADDR) begin
        rdata_q[7:0] <= ratio_view(hwStby_q ? scd_pkg::RATIO_RESET[1:0] : ratio_d);
      end else if (haddr == scd_pkg::CTRL_ADDR) begin
        rdata_q[scd_pkg::CTRL_PIN_EN_POS] <= pinEn_d;
      end else if (haddr == scd_pkg::STATUS_ADDR) begin
        rdata_q[scd_pkg::STAT_STBY_POS] <= (pwr_q != scd_pkg::RUN);
        rdata_q[scd_pkg::STAT_WAIT_POS] <= (pwr_q == scd_pkg::WAKE);
        rdata_q[scd_pkg::STAT_FAST_POS] <= osc.oscFast;
        rdata_q[scd_pkg::STAT_RATIO_POS +: 2] <= ratioAct_q;
      end
    end
  end

  assign hrdata = rdata_q;

  // ****************************************
  // Frequency divider
  // ****************************************
  assign divLast = ratio_last(ratioAct_q);
  assign phiTick = osc.oscTick & (divCnt_q == divLast);
  // Four bits wide, so the divide-by-eight half point does not wrap to zero
  assign divNext = {1'b0, divCnt_q} + 4'h1;
  assign divHalf = ({1'b0, divLast} + 4'h1) >> 1;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= 3'h0;
      ratioAct_q <= scd_pkg::RATIO_RESET[1:0];
    end else if (hwStby_q) begin
      divCnt_q <= 3'h0;
      ratioAct_q <= scd_pkg::RATIO_RESET[1:0];
    end else if (osc.oscTick) begin
      if (divCnt_q == divLast) begin
        divCnt_q <= 3'h0;
        // New ratio waits for the period end, so no runt pulse
        ratioAct_q <= ratio_q;
      end else begin
        divCnt_q <= divCnt_q + 3'h1;
      end
    end
  end

  // Pin level: high for the first half of each divided period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phiLvl_q <= 1'b0;
    end else if (hwStby_q) begin
      phiLvl_q <= 1'b0;
    end else if (osc.oscTick) begin
      if (divCnt_q == divLast) begin
        phiLvl_q <= 1'b1;
      end else begin
        phiLvl_q <= (divNext < divHalf);
      end
    end
  end

  // Undivided phi follows the oscillator wave directly, corrected when fast and filtered when slow
  // Gated by the enable itself, so a released pin never shows a stale high
  assign phiPin = (phiPinOe && pwr_q != scd_pkg::STBY) ?
    ((divLast == 3'h0) ? osc.oscWave : phiLvl_q) : 1'b0;
  assign phiPinOe = pinEn_q & ~hwStby_q;

  // ****************************************
  // Software standby sequencing
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= scd_pkg::RUN;
      waitCnt_q <= '0;
    end else if (hwStby_q) begin
      pwr_q <= scd_pkg::RUN;
      waitCnt_q <= '0;
    end else begin
      case (pwr_q)
        scd_pkg::RUN: begin
          if (stbyReq) begin
            pwr_q <= scd_pkg::STBY;
          end
        end
        scd_pkg::STBY: begin
          if (wake_q) begin
            pwr_q <= scd_pkg::WAKE;
            waitCnt_q <= '0;
          end
        end
        scd_pkg::WAKE: begin
          // Counted in phi periods, so a larger ratio waits longer
          if (phiTick) begin
            if (waitCnt_q == WAIT_LAST) begin
              pwr_q <= scd_pkg::RUN;
              waitCnt_q <= '0;
            end else begin
              waitCnt_q <= waitCnt_q + 1'b1;
            end
          end
        end
        default: begin
          pwr_q <= scd_pkg::RUN;
        end
      endcase
    end
  end

  // Divider runs on in software standby; the module ticks stop and the phi pin is held low until the wake wait
  assign modClkRun = (pwr_q == scd_pkg::RUN) & ~hwStby_q;
  assign standbyActive = (pwr_q != scd_pkg::RUN) | hwStby_q;

  // ****************************************
  // Prescalers for module clocks
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prescCnt_q <= '0;
    end else if (!modClkRun) begin
      prescCnt_q <= '0;
    end else if (phiTick) begin
      prescCnt_q <= prescCnt_q + 1'b1;
    end
  end

  // Stage k fires once every 2^(k+1) phi periods
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= '0;
      sysTick_q <= 1'b0;
    end else begin
      sysTick_q <= phiTick & modClkRun;
      for (int k = 0; k < PRESC_STAGES; k++) begin
        presc_q[k] <= phiTick & modClkRun &
          ((prescCnt_q & presc_mask(k)) == presc_mask(k));
      end
    end
  end

  assign sysTick = sysTick_q;
  assign prescTick = presc_q;

endmodule

// ### verification/scd_clock_divider_assertions.sv
`timescale 1ns/1ns
module scd_clock_divider_assertions #(
  parameter int unsigned PRESC_STAGES = 12
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic hwStandby,
  input wire logic sysTick,
  input wire logic [PRESC_STAGES-1:0] prescTick,
  input wire logic phiPin,
  input wire logic phiPinOe,
  input wire logic standbyActive
);
  // ****
  // Bus and clock checks
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic rdPhase;
  assign rdPhase = hsel && hready && htrans[1] && !hwrite;
  ok_response_a: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  zero_wait_a: assert property (hreadyout == 1'b1) else $error("hreadyout low");
  ratio_ones_a: assert property (
    rdPhase && haddr == scd_pkg::RATIO_ADDR |=> hrdata[31:2] == 30'h0000003F)
    else $error("ratio upper bits wrong");
  // Read data may only move after a read address phase
  read_hold_a: assert property (!$past(rdPhase) |-> $stable(hrdata))
    else $error("hrdata moved without read");
  phi_tick_a: assert property (sysTick |=> !sysTick) else $error("sysTick too long");
  presc_tick_a: assert property (
    prescTick[0] |=> !prescTick[0] [*3]) else $error("prescaler tick too close");
  pin_quiet_a: assert property (!phiPinOe |-> !phiPin) else $error("pin level undriven");
  hw_standby_a: assert property (
    hwStandby [*6] |-> standbyActive && !phiPinOe) else $error("hw standby ignored");
endmodule

bind scd_clock_divider scd_clock_divider_assertions #(.PRESC_STAGES(PRESC_STAGES)) u_chk (
  .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .hwStandby(hwStandby), .sysTick(sysTick), .prescTick(prescTick),
  .phiPin(phiPin), .phiPinOe(phiPinOe), .standbyActive(standbyActive));

// ### verification/scd_clock_divider_tb_top.sv
`timescale 1ns/1ns
module scd_clock_divider_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic oscRaw = 1'b0;
  logic hwStandby = 1'b0;
  logic wakeReq = 1'b0;
  logic sysTick;
  logic [11:0] prescTick;
  logic phiPin;
  logic phiPinOe;
  logic standbyActive;
  logic probe;
  logic [31:0] rd;
  int n_errors = 0;
  int comparisons = 0;
  int oscHalf = 2;
  int oscCnt = 0;
  int probeSel = -1;
  int n;
  always #50 clock = ~clock;
  // Slow oscillator by default: period of four clocks, below the fast limit
  always @(posedge clock) begin
    if (oscCnt + 1 >= oscHalf) begin
      oscRaw <= ~oscRaw;
      oscCnt <= 0;
    end else begin
      oscCnt <= oscCnt + 1;
    end
  end
  assign probe = (probeSel == -2) ? phiPin : (probeSel < 0) ? sysTick : prescTick[probeSel];
  scd_clock_divider #(.PRESC_STAGES(12), .STBY_WAIT_STATES(4)) u_scd_clock_divider (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .oscRaw(oscRaw),
    .hwStandby(hwStandby), .wakeReq(wakeReq), .sysTick(sysTick), .prescTick(prescTick),
    .phiPin(phiPin), .phiPinOe(phiPinOe), .standbyActive(standbyActive));
  // ****
  // Helpers
  // ****
  task automatic summarize;
    $display("Counts: %0d comparisons, %0d errors", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic waitProbe(output int c);
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (probe !== 1'b1 && c < 400);
    if (c >= 400) begin
      chk(32'h0, 32'h1);
      summarize();
    end
  endtask
  // Bounded wait on the single slave's ready, sampled at the edge
  task automatic waitReady;
    int i;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (hready !== 1'b1 && i < 50);
    if (i >= 50) begin
      chk(32'h0, 32'h1);
      summarize();
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     input logic [2:0] sz);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= scd_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= sz;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 3'h2);
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0, 3'h2);
    chk(rd, exp);
  endtask
  // Early gaps may straddle a ratio change, so only the third one is kept
  task automatic gap(input int sel, output int c);
    probeSel = sel;
    waitProbe(c);
    waitProbe(c);
    waitProbe(c);
  endtask
  task automatic count(input int sel, input int len, output int h);
    probeSel = sel;
    h = 0;
    repeat (len) begin
      @(posedge clock);
      h += (probe === 1'b1);
    end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rdchk(scd_pkg::RATIO_ADDR, 32'h000000FC);
    rdchk(32'h00000000, 32'h00000000);
  endtask
  task automatic t_ratio;
    for (int r = 0; r < 4; r++) begin
      wr(scd_pkg::RATIO_ADDR, 32'hFFFFFF00 | r);
      rdchk(scd_pkg::RATIO_ADDR, 32'h000000FC | r);
      gap(-1, n);
      chk(n, 4 << r);
      // Active ratio only moves at a period end, so read it after the gap
      rdchk(scd_pkg::STATUS_ADDR, r << 3);
    end
    bus(scd_pkg::RATIO_ADDR, 1'b1, 32'h00000000, 3'h0);
    rdchk(scd_pkg::RATIO_ADDR, 32'h000000FF);
  endtask
  task automatic t_presc;
    wr(scd_pkg::RATIO_ADDR, 32'h0);
    gap(0, n);
    chk(n, 8);
    gap(1, n);
    chk(n, 16);
  endtask
  task automatic t_duty;
    oscHalf = 1;
    repeat (20) @(posedge clock);
    rdchk(scd_pkg::STATUS_ADDR, 32'h4);
    gap(-1, n);
    chk(n, 2);
    oscHalf = 2;
    repeat (20) @(posedge clock);
  endtask
  task automatic t_pin;
    wr(scd_pkg::CTRL_ADDR, 32'h1);
    count(-2, 32, n);
    chk(phiPinOe, 1'b1);
    chk(32'(n > 0 && n < 32), 32'h1);
  endtask
  task automatic t_soft;
    wr(scd_pkg::RATIO_ADDR, 32'h2);
    wr(scd_pkg::CTRL_ADDR, 32'h3);
    // A tick launched on the entry edge may still be in flight
    @(posedge clock);
    count(-1, 30, n);
    chk(standbyActive, 1'b1);
    chk(n, 0);
    rdchk(scd_pkg::RATIO_ADDR, 32'h000000FE);
    @(posedge clock);
    wakeReq <= 1'b1;
    n = 0;
    while (standbyActive !== 1'b0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    // Four wait states of sixteen clocks each, less one partial period
    chk(32'(n >= 48 && n < 150), 32'h1);
    wakeReq <= 1'b0;
    rdchk(scd_pkg::RATIO_ADDR, 32'h000000FE);
    gap(-1, n);
    chk(n, 16);
  endtask
  task automatic t_hard;
    wr(scd_pkg::RATIO_ADDR, 32'h3);
    hwStandby <= 1'b1;
    repeat (8) @(posedge clock);
    chk(standbyActive, 1'b1);
    chk(phiPinOe, 1'b0);
    hwStandby <= 1'b0;
    repeat (8) @(posedge clock);
    rdchk(scd_pkg::RATIO_ADDR, 32'h000000FC);
    gap(-1, n);
    chk(n, 4);
    chk(phiPinOe, 1'b0);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_ratio();
    t_presc();
    t_duty();
    t_pin();
    t_soft();
    t_hard();
    summarize();
  end
endmodule
